// file: rpm_params.svh
// timing counts and reset values for the reset and port mode select block
// assumes inclusion by the top module only
`ifndef RPM_PARAMS_SVH
`define RPM_PARAMS_SVH
`define RPM_SYNC_STAGES 3
`define RPM_RST_STAGES 2
`define RPM_SLEW_HD 1'h1
`define RPM_SLEW_SD 1'h0
`define RPM_PORT_HOST 1'h0
`define RPM_PORT_TEST 1'h1
`define RPM_PIN_IDLE 7'h10
`endif

// file: rpm_partner.sv
// board controller model: drives the static mode pins and the reset pin
// assumes the bench asks for levels between falling edges
`timescale 1ns/1ps
module rpm_partner (
   input wire logic i_ref_clk,
   input wire logic [4:0] i_want,
   output logic [4:0] o_pins
);
   // pins: {master, port, rate, enable, reset_n}; reset starts high so its fall is an edge
   logic [4:0] pins_r = 5'h01;
   int hold_r = 0;
   assign o_pins = pins_r;
   always @(negedge i_ref_clk) begin
      if (i_want[2] != pins_r[2] && !i_want[4]) begin
         hold_r <= 2;
         pins_r <= {i_want[4:1], 1'b0};
      end else if (hold_r > 0) begin
         hold_r <= hold_r - 1;
         pins_r <= {i_want[4:1], 1'b0};
      end else begin
         pins_r <= i_want;
      end
   end
endmodule

// file: rpm_pkg.sv
// types for the reset and port mode select block
// assumes rpm_params.svh is on the include path
package rpm_pkg;
   typedef enum logic [1:0] {RPM_IN_RESET, RPM_HOST, RPM_TEST} rpm_mode_e;
endpackage

// file: rpm_top.sv
// reset and port mode select: loop-through output control, reset handling, shared pin mux
// assumes all mode pins are asynchronous to i_ref_clk; slave-side settings come from outside
`timescale 1ns/1ps
`include "rpm_params.svh"
module rpm_top
   import rpm_pkg::*;
#(
   parameter int RST_STAGES = `RPM_RST_STAGES,
   parameter int SYNC_STAGES = `RPM_SYNC_STAGES
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_loopthru_out_enable,
   input wire logic i_line_rate_select,
   input wire logic i_port_select,
   input wire logic i_master_slave,
   input wire logic i_loopthru_data,
   input wire logic i_pin_select,
   input wire logic i_pin_clock,
   input wire logic i_port_serial_in_shared,
   input wire logic i_host_data_out,
   input wire logic i_test_data_out,
   output logic o_loopthru_serial_out_p,
   output logic o_loopthru_serial_out_n,
   output logic o_loopthru_serial_out_oe,
   output logic o_slew_hd,
   output logic o_port_serial_out_shared,
   output logic o_port_serial_out_shared_oe,
   output logic o_host_select_n,
   output logic o_host_clock,
   output logic o_host_data_in,
   output logic o_test_mode_select,
   output logic o_test_clock,
   output logic o_test_data_in,
   output logic o_test_reset_n,
   output logic o_core_reset_n,
   output logic o_slave_mode
);

////////////////////////////////////////////////////////////////////////////////
// elaboration checks

// the reset release needs a shift of two or more
if (RST_STAGES < 2) begin : g_rst_stages_bad
   $error("reset synchroniser needs at least two stages");
end
// stages two and three are compared, so the count is fixed
if (SYNC_STAGES != 3) begin : g_sync_stages_bad
   $error("pin synchroniser supports exactly three stages");
end

////////////////////////////////////////////////////////////////////////////////
// internal reset: async assert, sync release so all blocks leave default together

// two stages trade one cycle of latency for metastability margin
logic [RST_STAGES-1:0] rst_sync_r;
logic [RST_STAGES-1:0] rst_sync_nxt;

always_comb begin
   rst_sync_nxt = {rst_sync_r[RST_STAGES-2:0], 1'h1};
end

always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      rst_sync_r <= '0;
   end else begin
      rst_sync_r <= rst_sync_nxt;
   end
end

// rst_core_n also resets the pin synchronisers, so they restart with the core
logic rst_core_n;
assign rst_core_n = rst_sync_r[RST_STAGES-1];

////////////////////////////////////////////////////////////////////////////////
// pin input synchronisers: three stages, change taken when stages two and three agree

// a one-cycle glitch never reaches stable_r, since stages two and three disagree
localparam int NSYNC = 7;
logic [NSYNC-1:0] pin_raw;
logic [NSYNC-1:0] s1_r, s2_r, s3_r, stable_r;
logic [NSYNC-1:0] s1_nxt, s2_nxt, s3_nxt, stable_nxt;

// shared serial pins cross domains too; their strobes are slow, so the latency is harmless
assign pin_raw = {i_port_serial_in_shared, i_pin_clock, i_pin_select,
   i_master_slave, i_port_select, i_line_rate_select, i_loopthru_out_enable};

always_comb begin
   s1_nxt = pin_raw;
   s2_nxt = s1_r;
   s3_nxt = s2_r;
   stable_nxt = stable_r;
   for (int i = 0; i < NSYNC; i++) begin
      if (s2_r[i] == s3_r[i]) begin
         stable_nxt[i] = s3_r[i];
      end
   end
end

always_ff @(posedge i_ref_clk or negedge rst_core_n) begin
   if (!rst_core_n) begin
      // select pin idles high, so no false host select follows reset
      s1_r <= `RPM_PIN_IDLE;
      s2_r <= `RPM_PIN_IDLE;
      s3_r <= `RPM_PIN_IDLE;
      stable_r <= `RPM_PIN_IDLE;
   end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      stable_r <= stable_nxt;
   end
end

logic en_q, rate_q, port_q, master_q, sel_q, sclk_q, sin_q;
assign {sin_q, sclk_q, sel_q, master_q, port_q, rate_q, en_q} = stable_r;

////////////////////////////////////////////////////////////////////////////////
// mode state: leaves reset one cycle after the internal release
// and follows the synchronised port select from then on

rpm_mode_e mode_r, mode_nxt;

always_comb begin
   unique case (mode_r)
      RPM_IN_RESET: mode_nxt = (port_q == `RPM_PORT_TEST) ? RPM_TEST : RPM_HOST;
      RPM_HOST: mode_nxt = (port_q == `RPM_PORT_TEST) ? RPM_TEST : RPM_HOST;
      RPM_TEST: mode_nxt = (port_q == `RPM_PORT_TEST) ? RPM_TEST : RPM_HOST;
   endcase
end

always_ff @(posedge i_ref_clk or negedge rst_core_n) begin
   if (!rst_core_n) begin
      mode_r <= RPM_IN_RESET;
   end else begin
      mode_r <= mode_nxt;
   end
end

////////////////////////////////////////////////////////////////////////////////
// output registers; every pin output is registered, costing one cycle of latency
// trade: that cycle buys glitch-free pins on every mode change

logic lt_p_nxt, lt_n_nxt, lt_oe_nxt, slew_nxt;
logic so_nxt, so_oe_nxt, hsel_n_nxt, hclk_nxt, hdi_nxt;
logic tms_nxt, tck_nxt, tdi_nxt, trst_n_nxt, slave_nxt;
logic host_on, test_on;

always_comb begin
   host_on = (mode_r == RPM_HOST);
   test_on = (mode_r == RPM_TEST);
   // host_on and test_on never hold together
   // rate setting in slave mode is external; a rate change needs a reset from outside
   slave_nxt = ~master_q;
   slew_nxt = rate_q ? `RPM_SLEW_HD : `RPM_SLEW_SD;
   lt_oe_nxt = en_q && (mode_r != RPM_IN_RESET);
   lt_p_nxt = lt_oe_nxt & i_loopthru_data;
   lt_n_nxt = lt_oe_nxt & ~i_loopthru_data;
   // select pin: active-low host select, active-high test mode select
   // shared pins go quiet outside their own mode, so the idle port sees no strobes
   hsel_n_nxt = host_on ? sel_q : 1'h1;
   hclk_nxt = host_on & sclk_q;
   hdi_nxt = host_on & sin_q;
   tms_nxt = test_on & sel_q;
   tck_nxt = test_on & sclk_q;
   tdi_nxt = test_on & sin_q;
   trst_n_nxt = test_on;
   so_oe_nxt = host_on | test_on;
   so_nxt = test_on ? i_test_data_out : (host_on & i_host_data_out);
end

always_ff @(posedge i_ref_clk or negedge rst_core_n) begin
   if (!rst_core_n) begin
      o_loopthru_serial_out_p <= 1'h0;
      o_loopthru_serial_out_n <= 1'h0;
      o_loopthru_serial_out_oe <= 1'h0;
      o_slew_hd <= `RPM_SLEW_SD;
      o_port_serial_out_shared <= 1'h0;
      o_port_serial_out_shared_oe <= 1'h0;
      o_host_select_n <= 1'h1;
      o_host_clock <= 1'h0;
      o_host_data_in <= 1'h0;
      o_test_mode_select <= 1'h0;
      o_test_clock <= 1'h0;
      o_test_data_in <= 1'h0;
      o_test_reset_n <= 1'h0;
      o_core_reset_n <= 1'h0;
      o_slave_mode <= 1'h1;
   end else begin
      o_loopthru_serial_out_p <= lt_p_nxt;
      o_loopthru_serial_out_n <= lt_n_nxt;
      o_loopthru_serial_out_oe <= lt_oe_nxt;
      o_slew_hd <= slew_nxt;
      o_port_serial_out_shared <= so_nxt;
      o_port_serial_out_shared_oe <= so_oe_nxt;
      o_host_select_n <= hsel_n_nxt;
      o_host_clock <= hclk_nxt;
      o_host_data_in <= hdi_nxt;
      o_test_mode_select <= tms_nxt;
      o_test_clock <= tck_nxt;
      o_test_data_in <= tdi_nxt;
      o_test_reset_n <= trst_n_nxt;
      o_core_reset_n <= 1'h1;
      o_slave_mode <= slave_nxt;
   end
end

endmodule

// file: rpm_top_asserts.sv
// port-level checks for the reset and port mode select block
// assumes the mode pins change no closer than the 8-cycle settle window
`timescale 1ns/1ps
module rpm_top_asserts (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_loopthru_out_enable,
   input wire logic i_line_rate_select,
   input wire logic i_port_select,
   input wire logic i_pin_select,
   input wire logic o_loopthru_serial_out_p,
   input wire logic o_loopthru_serial_out_n,
   input wire logic o_loopthru_serial_out_oe,
   input wire logic o_slew_hd,
   input wire logic o_port_serial_out_shared_oe,
   input wire logic o_host_select_n,
   input wire logic o_test_mode_select,
   input wire logic o_test_reset_n,
   input wire logic o_core_reset_n
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   sequence test_on;
      (i_port_select && o_core_reset_n && $stable(i_pin_select))[*8];
   endsequence
   sequence host_on;
      (!i_port_select && o_core_reset_n && $stable(i_pin_select))[*8];
   endsequence
   oe_off_a:
      assert property ((!i_loopthru_out_enable)[*8] |-> !o_loopthru_serial_out_oe) else $error("oe on");
   oe_on_a:
      assert property ((i_loopthru_out_enable && o_core_reset_n)[*8] |-> o_loopthru_serial_out_oe)
      else $error("oe off");
   pair_hiz_a:
      assert property (!o_loopthru_serial_out_oe |-> !o_loopthru_serial_out_p
         && !o_loopthru_serial_out_n) else $error("pair driven");
   slew_mode_a:
      assert property ((o_core_reset_n && $stable(i_line_rate_select))[*8]
         |-> o_slew_hd == i_line_rate_select) else $error("slew wrong");
   reset_hiz_a:
      assert property (disable iff (1'b0) !i_rst_n |-> !o_loopthru_serial_out_oe
         && !o_port_serial_out_shared_oe && !o_test_reset_n && !o_core_reset_n)
      else $error("reset ignored");
   shared_oe_a:
      assert property (o_core_reset_n[*2] |-> o_port_serial_out_shared_oe)
      else $error("shared out off");
   sync_release_a:
      assert property ($rose(o_core_reset_n) |-> $past(i_rst_n, 2)) else $error("early release");
   test_port_a:
      assert property (test_on |-> o_test_reset_n && o_host_select_n
         && o_test_mode_select == i_pin_select) else $error("test port");
   host_port_a:
      assert property (host_on |-> !o_test_reset_n && !o_test_mode_select
         && o_host_select_n == i_pin_select) else $error("host port");
endmodule
bind rpm_top rpm_top_asserts rpm_top_asserts_i (
   .i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n),
   .i_loopthru_out_enable(i_loopthru_out_enable),
   .i_line_rate_select(i_line_rate_select),
   .i_port_select(i_port_select),
   .i_pin_select(i_pin_select),
   .o_loopthru_serial_out_p(o_loopthru_serial_out_p),
   .o_loopthru_serial_out_n(o_loopthru_serial_out_n),
   .o_loopthru_serial_out_oe(o_loopthru_serial_out_oe),
   .o_slew_hd(o_slew_hd),
   .o_port_serial_out_shared_oe(o_port_serial_out_shared_oe),
   .o_host_select_n(o_host_select_n),
   .o_test_mode_select(o_test_mode_select),
   .o_test_reset_n(o_test_reset_n),
   .o_core_reset_n(o_core_reset_n)
);

// file: tb_reset_and_port_mode_select.sv
// random settle-and-compare bench for the reset and port mode select block
// assumes outputs settle within 20 cycles of a pin change
`timescale 1ns/1ps
module tb_reset_and_port_mode_select;
   logic clk = 1'b0;
   logic [4:0] want = 5'h00;
   logic [4:0] pins;
   logic [5:0] sh = 6'h00;
   logic p, n, oe, hd, hs_n, tms, trst_n, crst_n, slave, r;
   logic so, so_oe, hclk, hdi, tck, tdi;
   int miscompares = 0;
   int num_checks = 0;
   initial forever #2 clk = ~clk;
   rpm_partner rpm_partner_i (.i_ref_clk(clk), .i_want(want), .o_pins(pins));
   rpm_top rpm_top_i (.i_ref_clk(clk), .i_rst_n(pins[0]), .i_loopthru_out_enable(pins[1]),
      .i_line_rate_select(pins[2]), .i_port_select(pins[3]), .i_master_slave(pins[4]),
      .i_loopthru_data(sh[0]), .i_pin_select(sh[1]), .i_pin_clock(sh[2]),
      .i_port_serial_in_shared(sh[3]), .i_host_data_out(sh[4]), .i_test_data_out(sh[5]),
      .o_loopthru_serial_out_p(p), .o_loopthru_serial_out_n(n), .o_loopthru_serial_out_oe(oe),
      .o_slew_hd(hd), .o_port_serial_out_shared(so), .o_port_serial_out_shared_oe(so_oe),
      .o_host_select_n(hs_n), .o_host_clock(hclk), .o_host_data_in(hdi),
      .o_test_mode_select(tms), .o_test_clock(tck), .o_test_data_in(tdi),
      .o_test_reset_n(trst_n), .o_core_reset_n(crst_n),
      .o_slave_mode(slave));
   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      void'($urandom(6));
      repeat (5) @(posedge clk);
      want <= 5'h01;
      for (int t = 0; t < 20 && crst_n !== 1'b1; t++) @(negedge clk);
      if (crst_n !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: reset release timed out", $time);
      end else begin
         for (int k = 0; k < 60; k++) begin
            @(posedge clk);
            want <= {4'($urandom), 1'(k % 8 != 7)};
            @(negedge clk);
            sh = 6'($urandom);
            repeat (20) @(negedge clk);
            r = want[0];
            chk(oe, r & want[1]);
            chk(p, r & want[1] & sh[0]);
            chk(n, r & want[1] & ~sh[0]);
            chk(hd, r & want[2]);
            chk(crst_n, r);
            chk(trst_n, r & want[3]);
            chk(hs_n, ~r | want[3] | sh[1]);
            chk(tms, r & want[3] & sh[1]);
            chk(slave, ~r | ~want[4]);
            chk(so_oe, r);
            chk(so, r & (want[3] ? sh[5] : sh[4]));
            chk(hclk, r & ~want[3] & sh[2]);
            chk(hdi, r & ~want[3] & sh[3]);
            chk(tck, r & want[3] & sh[2]);
            chk(tdi, r & want[3] & sh[3]);
         end
      end
      complete_run();
   end
endmodule
